// ### logic/esc_event_status.v
// Summary of operation
// - An event bit reaches the summary only when its mask bit is set.
// - Status byte bit 5 is set whenever any set event bit is enabled.
// - The 8-bit mask is written by the set command and returned by its query.
// - Reading the event register returns its contents and then clears it.
// - Event bits are 7 power-on, 6 user request, 5 command, 4 execution, 3 device, 2 query, 1 request control, 0 OPC.
// - The OPC set command sets event bit 0 once pending work is done.
// - The OPC query queues the value 1 once pending work is done.
// - OPC commands never stall the command stream.
// - Waveform time-setting and sequence compilation count as pending work.
// - The identity query answers maker, model, serial and revision in that order.
// - The learn query emits the setup and a learn program restores it.
// - Pass-control-back stores a bus address from 0 to 30.
// - Only primary addresses are accepted for pass-control-back.
// - Clear-status clears the status byte summary and the event register only.
// - Status byte bit 5 carries the event summary, weight 32.
//
// Purpose: Standard event status and common-command handling
// Assumes: Command parser supplies decoded strobes and numeric values
// Notes: Responses are numeric or selector codes for a formatter
`timescale 1ns/1ps
`include "esc_map.vh"
module esc_event_status #(
    parameter SETUP_W = 32
) (
    // Clock and reset
    input wire clk_i,
    input wire rst_n_i,
    // Decoded commands
    input wire cmd_valid_i,
    input wire [3:0] cmd_code_i,
    input wire [7:0] cmd_value_i,
    input wire cmd_secondary_i,
    input wire [SETUP_W-1:0] lrn_setup_i,
    // Event conditions, one-cycle pulses
    input wire ev_user_req_i,
    input wire ev_cmd_err_i,
    input wire ev_exec_err_i,
    input wire ev_dev_err_i,
    input wire ev_query_err_i,
    input wire ev_req_ctrl_i,
    // Overlapped work
    input wire wave_time_start_i,
    input wire wave_time_done_i,
    input wire sequence_compilation_start_i,
    input wire sequence_compilation_done_i,
    // Responses
    output reg rsp_valid_o,
    output reg [2:0] rsp_kind_o,
    output reg [7:0] rsp_value_o,
    output reg [SETUP_W-1:0] lrn_value_o,
    // Setup restore
    output reg setup_load_o,
    output reg [SETUP_W-1:0] setup_data_o,
    // Status
    output wire [7:0] event_status_enable_mask_o,
    output wire [7:0] standard_event_status_o,
    output wire esb_summary_o,
    output wire [7:0] stb_contrib_o,
    output wire [4:0] pcb_addr_o,
    output wire pcb_valid_o,
    output wire opc_busy_o
);
    reg [7:0] mask_reg;
    reg [7:0] evt_reg;
    reg [7:0] evt_next;
    reg [4:0] pcb_reg;
    reg pcb_valid_reg;
    wire opc_set_fire;
    wire opc_qry_fire;
    wire is_cmd;
    wire [7:0] ev_in;
    wire [7:0] evt_enabled;
    wire rsp_any;

    // One strobe per decoded command
    wire cmd_mask_set;
    wire cmd_mask_qry;
    wire cmd_evt_qry;
    wire cmd_opc_set;
    wire cmd_opc_qry;
    wire cmd_idn_qry;
    wire cmd_lrn_qry;
    wire cmd_lrn_set;
    wire cmd_pcb_set;
    wire cmd_cls;
    wire cmd_rst;
    wire evt_clear;
    wire pcb_in_range;
    wire pcb_ok;

    assign is_cmd = cmd_valid_i;
    assign cmd_mask_set = is_cmd && (cmd_code_i == `ESC_CMD_MASK_SET);
    assign cmd_mask_qry = is_cmd && (cmd_code_i == `ESC_CMD_MASK_QRY);
    assign cmd_evt_qry = is_cmd && (cmd_code_i == `ESC_CMD_EVT_QRY);
    assign cmd_opc_set = is_cmd && (cmd_code_i == `ESC_CMD_OPC_SET);
    assign cmd_opc_qry = is_cmd && (cmd_code_i == `ESC_CMD_OPC_QRY);
    assign cmd_idn_qry = is_cmd && (cmd_code_i == `ESC_CMD_IDN_QRY);
    assign cmd_lrn_qry = is_cmd && (cmd_code_i == `ESC_CMD_LRN_QRY);
    assign cmd_lrn_set = is_cmd && (cmd_code_i == `ESC_CMD_LRN_SET);
    assign cmd_pcb_set = is_cmd && (cmd_code_i == `ESC_CMD_PCB_SET);
    assign cmd_cls = is_cmd && (cmd_code_i == `ESC_CMD_CLS);
    assign cmd_rst = is_cmd && (cmd_code_i == `ESC_CMD_RST);
    assign rsp_any = cmd_mask_qry | cmd_evt_qry | cmd_idn_qry | cmd_lrn_qry;
    assign evt_clear = cmd_evt_qry || cmd_cls;
    // Out-of-range or secondary addresses leave the stored one alone
    assign pcb_in_range = (cmd_value_i <= {3'h0, `ESC_PCB_MAX});
    assign pcb_ok = cmd_pcb_set && !cmd_secondary_i && pcb_in_range;

    esc_opc_tracker #(
        .NUM_SRC(2)
    ) u_opc (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .op_start_i({sequence_compilation_start_i, wave_time_start_i}),
        .op_done_i({sequence_compilation_done_i, wave_time_done_i}),
        .arm_set_i(cmd_opc_set),
        .arm_qry_i(cmd_opc_qry),
        // Reset command drops armed requests
        .cancel_i(cmd_rst),
        .busy_o(opc_busy_o),
        .set_fire_o(opc_set_fire),
        .qry_fire_o(opc_qry_fire)
    );

    // Event inputs in their fixed positions
    assign ev_in[`ESC_EV_PON] = 1'b0;
    assign ev_in[`ESC_EV_URQ] = ev_user_req_i;
    assign ev_in[`ESC_EV_CME] = ev_cmd_err_i;
    assign ev_in[`ESC_EV_EXE] = ev_exec_err_i;
    assign ev_in[`ESC_EV_DDE] = ev_dev_err_i;
    assign ev_in[`ESC_EV_QYE] = ev_query_err_i;
    assign ev_in[`ESC_EV_RQC] = ev_req_ctrl_i;
    assign ev_in[`ESC_EV_OPC] = opc_set_fire;

    // Clear on read or clear-status, new events win
    always @* begin
        evt_next = evt_reg;
        if (evt_clear) begin
            evt_next = 8'h00;
        end
        evt_next = evt_next | ev_in;
    end

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mask_reg <= `ESC_MASK_RST;
            evt_reg <= `ESC_EVT_RST;
            pcb_reg <= 5'h00;
            pcb_valid_reg <= 1'b0;
        end else begin
            evt_reg <= evt_next;
            if (cmd_mask_set) begin
                mask_reg <= cmd_value_i;
            end
            if (pcb_ok) begin
                pcb_reg <= cmd_value_i[4:0];
                pcb_valid_reg <= 1'b1;
            end
        end
    end

    // Response path, opc query has priority over a same-cycle query
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rsp_valid_o <= 1'b0;
            rsp_kind_o <= 3'h0;
            rsp_value_o <= 8'h00;
            lrn_value_o <= {SETUP_W{1'b0}};
            setup_load_o <= 1'b0;
            setup_data_o <= {SETUP_W{1'b0}};
        end else begin
            rsp_valid_o <= 1'b0;
            setup_load_o <= 1'b0;
            if (opc_qry_fire) begin
                rsp_valid_o <= 1'b1;
                rsp_kind_o <= `ESC_RSP_NUM;
                rsp_value_o <= 8'h01;
            end else if (rsp_any) begin
                case (cmd_code_i)
                    `ESC_CMD_MASK_QRY: begin
                        rsp_valid_o <= 1'b1;
                        rsp_kind_o <= `ESC_RSP_NUM;
                        rsp_value_o <= mask_reg;
                    end
                    `ESC_CMD_EVT_QRY: begin
                        rsp_valid_o <= 1'b1;
                        rsp_kind_o <= `ESC_RSP_NUM;
                        rsp_value_o <= evt_reg;
                    end
                    `ESC_CMD_IDN_QRY: begin
                        rsp_valid_o <= 1'b1;
                        rsp_kind_o <= `ESC_RSP_IDN;
                        rsp_value_o <= 8'h00;
                    end
                    `ESC_CMD_LRN_QRY: begin
                        rsp_valid_o <= 1'b1;
                        rsp_kind_o <= `ESC_RSP_LRN;
                        rsp_value_o <= 8'h00;
                        lrn_value_o <= lrn_setup_i;
                    end
                    default: begin
                        rsp_valid_o <= 1'b0;
                    end
                endcase
            end
            if (cmd_lrn_set) begin
                setup_load_o <= 1'b1;
                setup_data_o <= lrn_setup_i;
            end
        end
    end

    // Enabled events feed the summary
    assign evt_enabled = evt_reg & mask_reg;
    assign esb_summary_o = |evt_enabled;
    assign stb_contrib_o = {2'b00, esb_summary_o, 5'b00000};
    assign event_status_enable_mask_o = mask_reg;
    assign standard_event_status_o = evt_reg;
    assign pcb_addr_o = pcb_reg;
    assign pcb_valid_o = pcb_valid_reg;
endmodule // esc_event_status

// ### logic/esc_map.vh
// Purpose: Constants for the event status and common-command block
// Assumes: Command codes are decoded upstream from the parser
// Notes: Definitions only
`ifndef ESC_MAP_VH
`define ESC_MAP_VH
// Event bit positions
`define ESC_EV_PON 7
`define ESC_EV_URQ 6
`define ESC_EV_CME 5
`define ESC_EV_EXE 4
`define ESC_EV_DDE 3
`define ESC_EV_QYE 2
`define ESC_EV_RQC 1
`define ESC_EV_OPC 0
// Summary bit in main status byte
`define ESC_STB_ESB 5
// Reset values
`define ESC_MASK_RST 8'h00
`define ESC_EVT_RST 8'h80
// Command codes
`define ESC_CMD_MASK_SET 4'h1
`define ESC_CMD_MASK_QRY 4'h2
`define ESC_CMD_EVT_QRY 4'h3
`define ESC_CMD_OPC_SET 4'h4
`define ESC_CMD_OPC_QRY 4'h5
`define ESC_CMD_IDN_QRY 4'h6
`define ESC_CMD_LRN_QRY 4'h7
`define ESC_CMD_LRN_SET 4'h8
`define ESC_CMD_PCB_SET 4'h9
`define ESC_CMD_CLS 4'hA
`define ESC_CMD_RST 4'hB
// Response kinds
`define ESC_RSP_NUM 3'h1
`define ESC_RSP_IDN 3'h2
`define ESC_RSP_LRN 3'h3
// Highest primary bus address
`define ESC_PCB_MAX 5'h1E
`endif

// ### logic/esc_opc_tracker.v
// Purpose: Tracks pending overlapped operations and operation-complete requests
// Assumes: Overlapped work reports start and done pulses
// Notes: Requests never stall the command stream
`timescale 1ns/1ps
module esc_opc_tracker #(
    parameter NUM_SRC = 2
) (
    // Clock and reset
    input wire clk_i,
    input wire rst_n_i,
    // Overlapped work
    input wire [NUM_SRC-1:0] op_start_i,
    input wire [NUM_SRC-1:0] op_done_i,
    // Requests
    input wire arm_set_i,
    input wire arm_qry_i,
    input wire cancel_i,
    // Completion
    output wire busy_o,
    output wire set_fire_o,
    output wire qry_fire_o
);
    reg [NUM_SRC-1:0] pend_reg;
    reg [NUM_SRC-1:0] pend_next;
    reg set_arm_reg;
    reg qry_arm_reg;
    integer k;

    always @* begin
        for (k = 0; k < NUM_SRC; k = k + 1) begin
            pend_next[k] = op_start_i[k] | (pend_reg[k] & ~op_done_i[k]);
        end
    end

    assign busy_o = |pend_reg;
    assign set_fire_o = set_arm_reg & ~busy_o;
    assign qry_fire_o = qry_arm_reg & ~busy_o;

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pend_reg <= {NUM_SRC{1'b0}};
            set_arm_reg <= 1'b0;
            qry_arm_reg <= 1'b0;
        end else if (cancel_i) begin
            pend_reg <= pend_next;
            set_arm_reg <= 1'b0;
            qry_arm_reg <= 1'b0;
        end else begin
            pend_reg <= pend_next;
            set_arm_reg <= arm_set_i | (set_arm_reg & busy_o);
            qry_arm_reg <= arm_qry_i | (qry_arm_reg & busy_o);
        end
    end
endmodule // esc_opc_tracker

// ### verif/esc_ctrl_model.sv
// Purpose: Bus controller model issuing decoded common commands
// Assumes: One command per call, changed at the falling edge
// Notes: Idle argument lines show the inverse of the last value
`timescale 1ns/1ps
module esc_ctrl_model (
    // Clock
    input wire clk_i,
    // Commands
    output logic cmd_valid_o = 1'b0,
    output logic [3:0] cmd_code_o = 4'h0,
    output logic [7:0] cmd_value_o = 8'h00,
    output logic cmd_secondary_o = 1'b0
);
    task send(input logic [3:0] c, input logic [7:0] v, input logic s);
        @(negedge clk_i);
        cmd_valid_o = 1'b1;
        cmd_code_o = c;
        cmd_value_o = v;
        cmd_secondary_o = s;
        @(negedge clk_i);
        cmd_valid_o = 1'b0;
        cmd_code_o = ~c;
        cmd_value_o = ~v;
        cmd_secondary_o = ~s;
    endtask
endmodule // esc_ctrl_model

// ### verif/esc_event_status_asserts.sv
// Purpose: Port checks for the event status block
// Assumes: One clock, async active-low reset
// Notes: Bound to the block by name
`timescale 1ns/1ps
module esc_event_status_asserts (
    // Watched ports
    input wire clk_i,
    input wire rst_n_i,
    input wire cmd_valid_i,
    input wire [3:0] cmd_code_i,
    input wire [7:0] cmd_value_i,
    input wire cmd_secondary_i,
    input wire ev_user_req_i,
    input wire ev_cmd_err_i,
    input wire ev_exec_err_i,
    input wire ev_dev_err_i,
    input wire ev_query_err_i,
    input wire ev_req_ctrl_i,
    input wire rsp_valid_o,
    input wire [2:0] rsp_kind_o,
    input wire [7:0] rsp_value_o,
    input wire [7:0] event_status_enable_mask_o,
    input wire [7:0] standard_event_status_o,
    input wire esb_summary_o,
    input wire [7:0] stb_contrib_o,
    input wire [4:0] pcb_addr_o,
    input wire pcb_valid_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    chk_sum_mask: assert property (esb_summary_o == |(standard_event_status_o & event_status_enable_mask_o))
        else $error("summary disagrees with enabled events");
    chk_stb_bit5: assert property (stb_contrib_o == {2'h0, esb_summary_o, 5'h00})
        else $error("summary not alone in bit 5");
    chk_evt_read: assert property (cmd_valid_i && cmd_code_i == 4'h3 |=>
        rsp_valid_o && rsp_kind_o == 3'h1 && rsp_value_o == $past(standard_event_status_o))
        else $error("event read answer wrong");
    chk_read_clear: assert property (cmd_valid_i && cmd_code_i == 4'h3 |=>
        (standard_event_status_o & 8'hFE) == {1'b0, $past({ev_user_req_i, ev_cmd_err_i, ev_exec_err_i,
        ev_dev_err_i, ev_query_err_i, ev_req_ctrl_i}), 1'b0}) else $error("event register not cleared by read");
    chk_mask_echo: assert property (cmd_valid_i && cmd_code_i == 4'h1 |=>
        event_status_enable_mask_o == $past(cmd_value_i)) else $error("mask not stored");
    chk_mask_qry: assert property (cmd_valid_i && cmd_code_i == 4'h2 |=>
        rsp_valid_o && rsp_value_o == event_status_enable_mask_o) else $error("mask query wrong");
    chk_pcb_range: assert property (pcb_valid_o |-> pcb_addr_o <= 5'h1E)
        else $error("pass-back address above 30");
    chk_pcb_refuse: assert property (cmd_valid_i && cmd_code_i == 4'h9 && (cmd_secondary_i || cmd_value_i > 8'h1E)
        |=> $stable({pcb_valid_o, pcb_addr_o})) else $error("bad pass-back address taken");
    chk_evt_latch: assert property (|($past(standard_event_status_o) & ~standard_event_status_o) |->
        $past(cmd_valid_i && (cmd_code_i == 4'h3 || cmd_code_i == 4'hA))) else $error("event bit lost");
endmodule // esc_event_status_asserts
bind esc_event_status esc_event_status_asserts esc_event_status_asserts_i (.*);

// ### verif/esc_event_status_bench.sv
// Purpose: Self-checking bench for the event status block
// Assumes: Controller model drives commands
// Notes: Responses checked against a queue of notes
`timescale 1ns/1ps
module esc_event_status_bench;
    logic clk_i = 0, rst_n_i = 0, rsp_valid_o, setup_load_o, esb_summary_o, pcb_valid_o, opc_busy_o;
    wire cmd_valid_i, cmd_secondary_i;
    wire [3:0] cmd_code_i;
    wire [7:0] cmd_value_i;
    logic [5:0] ev = 0;
    logic [3:0] op = 0;
    wire ev_req_ctrl_i = ev[0], ev_query_err_i = ev[1], ev_dev_err_i = ev[2], ev_exec_err_i = ev[3];
    wire ev_cmd_err_i = ev[4], ev_user_req_i = ev[5];
    wire wave_time_start_i = op[0], wave_time_done_i = op[1];
    wire sequence_compilation_start_i = op[2], sequence_compilation_done_i = op[3];
    logic [2:0] rsp_kind_o;
    logic [7:0] rsp_value_o, event_status_enable_mask_o, standard_event_status_o, stb_contrib_o, r;
    logic [31:0] lrn_setup_i = 0, lrn_value_o, setup_data_o;
    logic [4:0] pcb_addr_o;
    logic [10:0] exp_q[$];
    int n_mismatch = 0, comparisons = 0, k;
    always #50 clk_i = ~clk_i;
    esc_event_status esc_event_status_i (.*);
    esc_ctrl_model esc_ctrl_model_i (.clk_i(clk_i), .cmd_valid_o(cmd_valid_i), .cmd_code_o(cmd_code_i),
        .cmd_value_o(cmd_value_i), .cmd_secondary_o(cmd_secondary_i));
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    task cmd(input logic [3:0] c, input logic [7:0] v, input logic [10:0] e);
        if (e !== 11'h000) exp_q.push_back(e);
        esc_ctrl_model_i.send(c, v, 1'b0);
    endtask
    task drain;
        for (k = 0; k < 30 && exp_q.size() > 0; k++) cyc(1);
        if (exp_q.size() > 0) begin
            chk("pending", 1, 0);
            wrap_up();
        end
    endtask
    task wrap_up;
        $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(negedge clk_i) if (rsp_valid_o === 1'b1) begin
        if (exp_q.size() == 0) chk("extra", 1, 0);
        else chk("rsp", {rsp_kind_o, (rsp_kind_o == 3'h1) ? rsp_value_o : 8'h00}, exp_q.pop_front());
    end
    initial begin
        k = $urandom(48993);
        cyc(4);
        rst_n_i = 1;
        cmd(4'h3, 0, 11'h180);
        cmd(4'h3, 0, 11'h100);
        for (int i = 0; i < 6; i++) begin
            r = $urandom;
            r[i + 1] = i[0];
            ev[i] = 1;
            cyc(1);
            ev = 0;
            cmd(4'h1, r, 0);
            cmd(4'h2, 0, {3'h1, r});
            drain();
            chk("stb", stb_contrib_o, {i[0], 5'h00});
            cmd(4'h3, 0, {3'h1, 8'h01 << (i + 1)});
            drain();
        end
        op = 1;
        cyc(1);
        op = 0;
        cmd(4'h5, 0, 0);
        cmd(4'h2, 0, {3'h1, r});
        drain();
        chk("busy", opc_busy_o, 1);
        exp_q.push_back(11'h101);
        op = 2;
        cyc(1);
        op = 0;
        drain();
        chk("idle", opc_busy_o, 0);
        op = 4;
        cyc(1);
        op = 0;
        cmd(4'h4, 0, 0);
        cmd(4'h3, 0, 11'h100);
        op = 8;
        cyc(1);
        op = 0;
        cyc(3);
        cmd(4'h3, 0, 11'h101);
        cmd(4'h9, 30, 0);
        cmd(4'h9, 31, 0);
        esc_ctrl_model_i.send(4'h9, 8'h05, 1'b1);
        cyc(2);
        chk("pcb", {pcb_valid_o, pcb_addr_o}, 6'h3E);
        op = 1;
        cyc(1);
        op = 0;
        cmd(4'h4, 0, 0);
        cmd(4'h5, 0, 0);
        cmd(4'hB, 0, 0);
        op = 2;
        cyc(1);
        op = 0;
        cyc(3);
        chk("cancel", opc_busy_o, 0);
        cmd(4'h3, 0, 11'h100);
        ev = 6'h3F;
        cyc(1);
        ev = 0;
        cmd(4'hA, 0, 0);
        cmd(4'h3, 0, 11'h100);
        lrn_setup_i = $urandom;
        cmd(4'h6, 0, 11'h200);
        cmd(4'h7, 0, 11'h300);
        drain();
        chk("learn", lrn_value_o, lrn_setup_i);
        lrn_setup_i = ~lrn_setup_i;
        cmd(4'h8, 0, 0);
        chk("load", setup_load_o, 1);
        cyc(2);
        chk("restore", setup_data_o, lrn_setup_i);
        chk("load end", setup_load_o, 0);
        wrap_up();
    end
endmodule // esc_event_status_bench
